// File: logic/asp_pkg.sv
// Constants and carrier types shared by the serial port block
package asp_pkg;
  localparam int ASP_DEPTH = 16;
  localparam logic [3:0] ASP_TICK_MID = 4'h7;
  localparam logic [3:0] ASP_TICK_LAST = 4'hf;
  localparam logic [3:0] ASP_BYTE_BITS = 4'h8;
  localparam logic [3:0] ASP_MIN_BITS = 4'h5;
  localparam logic [10:0] ASP_TO_TICKS = 11'h040;
  localparam int ASP_LSR_DR = 0;
  localparam int ASP_LSR_OE = 1;
  localparam int ASP_LSR_PE = 2;
  localparam int ASP_LSR_FE = 3;
  localparam int ASP_LSR_BI = 4;
  localparam int ASP_LSR_HOLDING_EMPTY_FLAG = 5;
  localparam int ASP_LSR_TEMT = 6;
  localparam int ASP_LSR_ERR = 7;
  localparam logic [7:0] ASP_LSR_RST = 8'h60;
  localparam int ASP_MS_CTS = 0;
  localparam int ASP_MS_DSR = 1;
  localparam int ASP_MS_RI = 2;
  localparam int ASP_MS_DCD = 3;
  typedef enum logic [2:0] {
    ASP_LEN_5 = 3'b000,
    ASP_LEN_6 = 3'b001,
    ASP_LEN_7 = 3'b010,
    ASP_LEN_8 = 3'b011,
    ASP_LEN_9 = 3'b100
  } asp_len_type;
  typedef enum logic [2:0] {
    ASP_PAR_NONE = 3'b000,
    ASP_PAR_EVEN = 3'b001,
    ASP_PAR_ODD = 3'b010,
    ASP_PAR_SPACE = 3'b011,
    ASP_PAR_MARK = 3'b100
  } asp_par_type;
  typedef struct packed {
    asp_len_type len;
    asp_par_type par;
    logic two_stop;
    logic brk;
  } asp_lctl_type;
  typedef struct packed {
    logic rx;
    logic holding_empty_flag;
    logic temt;
    logic ls;
    logic ms;
  } asp_ien_type;
  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } asp_rx_entry_type;
endpackage

// File: logic/asp_uart_top.sv
// Serial port with transmit and receive queues and modem handshake lines
`timescale 1ns/1ps
// Notes on behaviour
// - Separate sixteen-byte queues for transmit and receive.
// - Five to nine data bits, same setting both directions.
// - Parity even, odd, space, mark, address/data or none.
// - One start bit, one or two stop bits sent; start and first stop bit checked.
// - Break can be driven on transmit and is detected on receive.
// - Queues can be switched on or off; receive trigger level compared.
// - Holding register is write only; up to eighteen bytes queue up, sixteen in the queue and two in the buffer ahead of it.
// - After reset holding register empty, its flag one, interrupt raised.
// - Writing the holding register clears the empty interrupt.
// - Least significant bit first, framed by configured protocol bits.
// - Transmit-complete interrupt after last bit; next write clears it.
// - Transmit line rests high when nothing is left to send.
// - One serial bit per sixteen baud ticks on transmit.
// - Nine-bit transmit: mark means address, space means data.
// - Data ready sets on a received byte, clears when all read.
// - Unused upper bits of short characters read as zero.
// - Nine-bit receive expects space; high ninth bit raises line status.
// - Receiver at sixteen times baud, aligned on start bit falling edge.
// - Framing, parity and break flagged per character; overrun in one flag held until line status is read.
// - Two handshake outputs, four inputs; any change except ring interrupts.
// - Ring indicate interrupts only on its trailing edge.
// - Loopback routes transmit data back to the receiver.
// - Below trigger and idle four character times raises time-out.
// - With queues on, data ready interrupt when count reaches trigger.
// - Line status interrupt clears when line status is read.
// - Modem status interrupt clears when modem status is read.
module asp_uart_top #(
  parameter int DEPTH = asp_pkg::ASP_DEPTH, // Queue depth, power of two
  parameter int CW = $clog2(DEPTH) + 1 // Queue count width
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic baud_tick, // Pulse at sixteen times bit rate
  input wire asp_pkg::asp_lctl_type lctl, // Character format and break
  input wire logic fifo_en, // Queues enabled
  input wire logic [CW-1:0] rx_trig, // Receive trigger level
  input wire logic loop_en, // Loopback mode
  input wire asp_pkg::asp_ien_type int_en, // Interrupt enables
  input wire logic mctl_rts, // Request to send, active high
  input wire logic mctl_dtr, // Terminal ready, active high
  input wire logic thr_wr, // Holding register write strobe
  input wire logic [7:0] thr_data, // Holding register write data
  output logic thr_ready, // Holding register can take a byte
  input wire logic rbr_rd, // Receive buffer read strobe
  output logic [7:0] rbr_data, // Receive buffer front byte
  input wire logic lsr_rd, // Line status read strobe
  output logic [7:0] line_status, // Line status register
  input wire logic msr_rd, // Modem status read strobe
  output logic [7:0] modem_status, // Modem status register
  output logic rx_irq, // Data ready or time-out interrupt
  output logic holding_empty_flag_irq, // Holding empty interrupt
  output logic temt_irq, // Transmission complete interrupt
  output logic ls_irq, // Line status interrupt
  output logic ms_irq, // Modem status interrupt
  output logic txd, // Serial transmit pin
  input wire logic rxd, // Serial receive pin
  input wire logic cts_n, // Clear to send pin
  input wire logic dsr_n, // Data set ready pin
  input wire logic dcd_n, // Carrier detect pin
  input wire logic ri_n, // Ring indicate pin
  output logic rts_n, // Request to send pin
  output logic dtr_n // Terminal ready pin
);
  localparam int AW = CW - 1;
  localparam logic [CW-1:0] CAP_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CAP_ONE = CW'(1);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } asp_tx_state_type;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } asp_rx_state_type;

  // In nine-bit mode the parity slot carries the address mark
  function automatic logic par_f(asp_pkg::asp_lctl_type c, logic [7:0] d);
    logic l9;
    l9 = (c.len == asp_pkg::ASP_LEN_9);
    par_f = (c.par == asp_pkg::ASP_PAR_MARK) | (!l9 &
            (((c.par == asp_pkg::ASP_PAR_EVEN) & ^d) |
             ((c.par == asp_pkg::ASP_PAR_ODD) & ~^d)));
  endfunction

  logic len9;
  logic [3:0] nbits;
  logic has_par;
  logic [7:0] dmask;
  logic [CW-1:0] cap;
  assign len9 = (lctl.len == asp_pkg::ASP_LEN_9);
  assign nbits = len9 ? asp_pkg::ASP_BYTE_BITS :
                 asp_pkg::ASP_MIN_BITS + 4'(lctl.len);
  assign has_par = len9 || (lctl.par != asp_pkg::ASP_PAR_NONE);
  assign dmask = 8'hff >> (asp_pkg::ASP_BYTE_BITS - nbits);
  assign cap = fifo_en ? CAP_FULL : CAP_ONE;

  // Two-entry buffer in front of the transmit queue
  logic [7:0] sk_mem_r [2];
  logic [1:0] sk_cnt_r;
  logic [1:0] sk_cnt_nxt;
  logic sk_wp_r;
  logic sk_rp_r;
  logic thr_ready_r;
  logic sk_push;
  logic sk_pop;
  logic [7:0] txf_mem_r [DEPTH];
  logic [AW-1:0] txf_wp_r;
  logic [AW-1:0] txf_rp_r;
  logic [CW-1:0] txf_cnt_r;
  logic txf_pop;
  assign sk_push = thr_wr && thr_ready_r;
  assign sk_pop = (sk_cnt_r != 2'h0) && (txf_cnt_r < cap);
  assign sk_cnt_nxt = sk_cnt_r + 2'(sk_push) - 2'(sk_pop);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sk_cnt_r <= 2'h0;
      sk_wp_r <= 1'b0;
      sk_rp_r <= 1'b0;
      thr_ready_r <= 1'b0;
    end else begin
      sk_cnt_r <= sk_cnt_nxt;
      thr_ready_r <= (sk_cnt_nxt != 2'h2);
      if (sk_push) begin
        sk_wp_r <= !sk_wp_r;
      end
      if (sk_pop) begin
        sk_rp_r <= !sk_rp_r;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sk_push) begin
      sk_mem_r[sk_wp_r] <= thr_data;
    end
    if (sk_pop) begin
      txf_mem_r[txf_wp_r] <= sk_mem_r[sk_rp_r];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txf_wp_r <= '0;
      txf_rp_r <= '0;
      txf_cnt_r <= '0;
    end else begin
      txf_cnt_r <= txf_cnt_r + CW'(sk_pop) - CW'(txf_pop);
      if (sk_pop) begin
        txf_wp_r <= txf_wp_r + AW'(1);
      end
      if (txf_pop) begin
        txf_rp_r <= txf_rp_r + AW'(1);
      end
    end
  end

  // Transmit shifter
  asp_tx_state_type tx_st_r;
  logic [3:0] tx_tick_r;
  logic [3:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic tx_par_r;
  logic tx_line_r;
  logic tx_end;
  logic tx_done;
  logic tx_eff;
  assign txf_pop = (tx_st_r == TX_IDLE) && (txf_cnt_r != '0);
  assign tx_end = baud_tick && (tx_tick_r == asp_pkg::ASP_TICK_LAST);
  assign tx_done = tx_end && (tx_st_r == TX_STOP) &&
                   !(lctl.two_stop && (tx_bit_r == 4'h0));
  assign tx_eff = tx_line_r && !lctl.brk;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_st_r <= TX_IDLE;
      tx_tick_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      if (tx_st_r == TX_IDLE) begin
        tx_tick_r <= 4'h0;
      end else if (baud_tick) begin
        tx_tick_r <= tx_tick_r + 4'h1;
      end
      unique case (tx_st_r)
        TX_IDLE: if (txf_pop) begin
          tx_sh_r <= txf_mem_r[txf_rp_r] & dmask;
          tx_par_r <= par_f(lctl, txf_mem_r[txf_rp_r] & dmask);
          tx_line_r <= 1'b0;
          tx_st_r <= TX_START;
        end
        TX_START: if (tx_end) begin
          tx_line_r <= tx_sh_r[0];
          tx_sh_r <= tx_sh_r >> 1;
          tx_bit_r <= 4'h1;
          tx_st_r <= TX_DATA;
        end
        TX_DATA: if (tx_end) begin
          if (tx_bit_r != nbits) begin
            tx_line_r <= tx_sh_r[0];
            tx_sh_r <= tx_sh_r >> 1;
            tx_bit_r <= tx_bit_r + 4'h1;
          end else if (has_par) begin
            tx_line_r <= tx_par_r;
            tx_st_r <= TX_PAR;
          end else begin
            tx_line_r <= 1'b1;
            tx_bit_r <= 4'h0;
            tx_st_r <= TX_STOP;
          end
        end
        TX_PAR: if (tx_end) begin
          tx_line_r <= 1'b1;
          tx_bit_r <= 4'h0;
          tx_st_r <= TX_STOP;
        end
        TX_STOP: if (tx_end) begin
          if (tx_done) begin
            tx_st_r <= TX_IDLE;
          end else begin
            tx_bit_r <= 4'h1;
          end
        end
      endcase
    end
  end

  // Receive line: two-stage synchroniser, then start-edge search
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_prev_r;
  logic rx_in;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
    end
  end
  assign rx_in = loop_en ? tx_eff : rx_s2_r;

  asp_rx_state_type rx_st_r;
  logic [3:0] rx_tick_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_pbit_r;
  logic rx_any_r;
  logic rx_smp;
  logic rx_push;
  logic [7:0] rx_data;
  logic rx_pe;
  asp_pkg::asp_rx_entry_type rx_ent;
  assign rx_smp = baud_tick && (rx_tick_r == asp_pkg::ASP_TICK_MID);
  assign rx_push = rx_smp && (rx_st_r == RX_STOP);
  assign rx_data = rx_sh_r >> (asp_pkg::ASP_BYTE_BITS - nbits);
  // Nine-bit mode always expects space, so an address shows as parity error
  assign rx_pe = has_par &&
                 (rx_pbit_r != (!len9 && par_f(lctl, rx_data)));
  assign rx_ent = {!rx_any_r && !rx_in, !rx_in, rx_pe, rx_data};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_st_r <= RX_IDLE;
      rx_tick_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_pbit_r <= 1'b0;
      rx_any_r <= 1'b0;
      rx_prev_r <= 1'b1;
    end else begin
      if (baud_tick) begin
        rx_prev_r <= rx_in;
      end
      if (rx_st_r == RX_IDLE) begin
        rx_tick_r <= 4'h0;
      end else if (baud_tick) begin
        rx_tick_r <= rx_tick_r + 4'h1;
      end
      unique case (rx_st_r)
        RX_IDLE: if (baud_tick && rx_prev_r && !rx_in) begin
          rx_st_r <= RX_START;
          rx_bit_r <= 4'h0;
          rx_any_r <= 1'b0;
          rx_pbit_r <= 1'b0;
        end
        RX_START: if (rx_smp) begin
          rx_st_r <= rx_in ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_smp) begin
          rx_sh_r <= {rx_in, rx_sh_r[7:1]};
          rx_any_r <= rx_any_r | rx_in;
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r + 4'h1 == nbits) begin
            rx_st_r <= has_par ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (rx_smp) begin
          rx_pbit_r <= rx_in;
          rx_any_r <= rx_any_r | rx_in;
          rx_st_r <= RX_STOP;
        end
        RX_STOP: if (rx_smp) begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Receive queue; the front entry carries its own error flags
  asp_pkg::asp_rx_entry_type rxf_mem_r [DEPTH];
  asp_pkg::asp_rx_entry_type rxf_head;
  logic [AW-1:0] rxf_wp_r;
  logic [AW-1:0] rxf_rp_r;
  logic [CW-1:0] rxf_cnt_r;
  logic rxf_push;
  logic rxf_pop;
  logic rx_ovr;
  logic rx_nz;
  assign rxf_push = rx_push && (rxf_cnt_r < cap);
  assign rx_ovr = rx_push && (rxf_cnt_r >= cap);
  assign rxf_pop = rbr_rd && (rxf_cnt_r != '0);
  assign rxf_head = rxf_mem_r[rxf_rp_r];
  assign rx_nz = (rxf_cnt_r != '0);

  always_ff @(posedge core_clk) begin
    if (rxf_push) begin
      rxf_mem_r[rxf_wp_r] <= rx_ent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxf_wp_r <= '0;
      rxf_rp_r <= '0;
      rxf_cnt_r <= '0;
    end else begin
      rxf_cnt_r <= rxf_cnt_r + CW'(rxf_push) - CW'(rxf_pop);
      if (rxf_push) begin
        rxf_wp_r <= rxf_wp_r + AW'(1);
      end
      if (rxf_pop) begin
        rxf_rp_r <= rxf_rp_r + AW'(1);
      end
    end
  end

  // Receive time-out, counted in baud ticks
  logic [3:0] char_bits;
  logic [10:0] to_lim;
  logic [10:0] to_cnt_r;
  logic to_pend_r;
  logic rx_lvl;
  assign char_bits = 4'h2 + nbits + 4'(has_par) + 4'(lctl.two_stop);
  assign to_lim = 11'(char_bits) * asp_pkg::ASP_TO_TICKS;
  assign rx_lvl = fifo_en ? (rxf_cnt_r >= rx_trig) : rx_nz;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      to_cnt_r <= 11'h000;
      to_pend_r <= 1'b0;
    end else begin
      if (rxf_push || rxf_pop || !rx_nz) begin
        to_cnt_r <= 11'h000;
      end else if (baud_tick && (to_cnt_r < to_lim)) begin
        to_cnt_r <= to_cnt_r + 11'h001;
      end
      if (fifo_en && rx_nz && (rxf_cnt_r < rx_trig) &&
          (to_cnt_r >= to_lim)) begin
        to_pend_r <= 1'b1;
      end else if (!rx_nz) begin
        to_pend_r <= 1'b0;
      end
    end
  end

  // Line status and transmit events; a set always beats a clear
  logic head_err;
  logic holding_empty_flag;
  logic temt;
  logic oe_r;
  logic ls_pend_r;
  logic hd_chk_r;
  logic holding_empty_flag_prev_r;
  logic holding_empty_flag_pend_r;
  logic temt_pend_r;
  logic [7:0] lsr_nxt;
  assign head_err = rx_nz && (rxf_head.bi || rxf_head.fe || rxf_head.pe);
  assign holding_empty_flag = (sk_cnt_r == 2'h0) && (txf_cnt_r == '0);
  assign temt = holding_empty_flag && (tx_st_r == TX_IDLE);

  always_comb begin
    lsr_nxt = 8'h00;
    lsr_nxt[asp_pkg::ASP_LSR_DR] = rx_nz;
    lsr_nxt[asp_pkg::ASP_LSR_OE] = oe_r;
    lsr_nxt[asp_pkg::ASP_LSR_PE] = rx_nz && rxf_head.pe;
    lsr_nxt[asp_pkg::ASP_LSR_FE] = rx_nz && rxf_head.fe;
    lsr_nxt[asp_pkg::ASP_LSR_BI] = rx_nz && rxf_head.bi;
    lsr_nxt[asp_pkg::ASP_LSR_HOLDING_EMPTY_FLAG] = holding_empty_flag;
    lsr_nxt[asp_pkg::ASP_LSR_TEMT] = temt;
    lsr_nxt[asp_pkg::ASP_LSR_ERR] = head_err;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
      ls_pend_r <= 1'b0;
      hd_chk_r <= 1'b0;
    end else begin
      hd_chk_r <= rxf_pop || (rxf_push && !rx_nz);
      if (rx_ovr) begin
        oe_r <= 1'b1;
      end else if (lsr_rd) begin
        oe_r <= 1'b0;
      end
      if (rx_ovr || (hd_chk_r && head_err)) begin
        ls_pend_r <= 1'b1;
      end else if (lsr_rd) begin
        ls_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      holding_empty_flag_prev_r <= 1'b1;
      holding_empty_flag_pend_r <= 1'b1;
      temt_pend_r <= 1'b0;
    end else begin
      holding_empty_flag_prev_r <= holding_empty_flag;
      if (holding_empty_flag && !holding_empty_flag_prev_r) begin
        holding_empty_flag_pend_r <= 1'b1;
      end else if (sk_push) begin
        holding_empty_flag_pend_r <= 1'b0;
      end
      if (tx_done && holding_empty_flag) begin
        temt_pend_r <= 1'b1;
      end else if (sk_push) begin
        temt_pend_r <= 1'b0;
      end
    end
  end

  // Modem inputs: synchronised per pin, then change detection
  logic [3:0] md_pins;
  logic [3:0] md_s1_r;
  logic [3:0] md_s2_r;
  logic [3:0] md_in;
  logic [3:0] md_prev_r;
  logic [3:0] ms_delta_r;
  assign md_pins = ~{dcd_n, ri_n, dsr_n, cts_n};

  always_comb begin
    md_in = md_s2_r;
    if (loop_en) begin
      md_in = 4'h0;
      md_in[asp_pkg::ASP_MS_CTS] = mctl_rts;
      md_in[asp_pkg::ASP_MS_DSR] = mctl_dtr;
    end
  end

  for (genvar gi = 0; gi < 4; gi++) begin : g_modem
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        md_s1_r[gi] <= 1'b0;
        md_s2_r[gi] <= 1'b0;
        md_prev_r[gi] <= 1'b0;
        ms_delta_r[gi] <= 1'b0;
      end else begin
        md_s1_r[gi] <= md_pins[gi];
        md_s2_r[gi] <= md_s1_r[gi];
        md_prev_r[gi] <= md_in[gi];
        if ((gi == asp_pkg::ASP_MS_RI) ? (md_prev_r[gi] && !md_in[gi]) :
            (md_prev_r[gi] != md_in[gi])) begin
          ms_delta_r[gi] <= 1'b1;
        end else if (msr_rd) begin
          ms_delta_r[gi] <= 1'b0;
        end
      end
    end
  end

  // Registered outputs
  logic [7:0] rbr_data_r;
  logic [7:0] line_status_r;
  logic [7:0] modem_status_r;
  logic rx_irq_r;
  logic holding_empty_flag_irq_r;
  logic temt_irq_r;
  logic ls_irq_r;
  logic ms_irq_r;
  logic txd_r;
  logic rts_n_r;
  logic dtr_n_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rbr_data_r <= 8'h00;
      line_status_r <= asp_pkg::ASP_LSR_RST;
      modem_status_r <= 8'h00;
      txd_r <= 1'b1;
      rts_n_r <= 1'b1;
      dtr_n_r <= 1'b1;
    end else begin
      rbr_data_r <= rx_nz ? rxf_head.data : 8'h00;
      line_status_r <= lsr_nxt;
      modem_status_r <= {md_in, ms_delta_r};
      // Pin stays idle during loopback so the far end sees no traffic
      txd_r <= loop_en || tx_eff;
      rts_n_r <= loop_en || !mctl_rts;
      dtr_n_r <= loop_en || !mctl_dtr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_irq_r <= 1'b0;
      holding_empty_flag_irq_r <= 1'b0;
      temt_irq_r <= 1'b0;
      ls_irq_r <= 1'b0;
      ms_irq_r <= 1'b0;
    end else begin
      rx_irq_r <= int_en.rx && (rx_lvl || to_pend_r);
      holding_empty_flag_irq_r <= int_en.holding_empty_flag && holding_empty_flag_pend_r;
      temt_irq_r <= int_en.temt && temt_pend_r;
      ls_irq_r <= int_en.ls && ls_pend_r;
      ms_irq_r <= int_en.ms && (ms_delta_r != 4'h0);
    end
  end

  assign thr_ready = thr_ready_r;
  assign rbr_data = rbr_data_r;
  assign line_status = line_status_r;
  assign modem_status = modem_status_r;
  assign rx_irq = rx_irq_r;
  assign holding_empty_flag_irq = holding_empty_flag_irq_r;
  assign temt_irq = temt_irq_r;
  assign ls_irq = ls_irq_r;
  assign ms_irq = ms_irq_r;
  assign txd = txd_r;
  assign rts_n = rts_n_r;
  assign dtr_n = dtr_n_r;

  a_queue_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rxf_cnt_r <= CAP_FULL) && (txf_cnt_r <= CAP_FULL))
    else $error("queue count above depth");
  a_holding_empty_flag_reset: assert property (@(posedge core_clk)
    $rose(rst_n) |-> line_status_r[asp_pkg::ASP_LSR_HOLDING_EMPTY_FLAG] && holding_empty_flag_pend_r)
    else $error("holding empty not shown after reset");
  a_write_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    sk_push && !(holding_empty_flag && !holding_empty_flag_prev_r) |=> !holding_empty_flag_pend_r)
    else $error("write did not clear holding empty");
  a_bit_period: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(tx_st_r) != TX_IDLE) && $changed(tx_line_r) |->
    $past(baud_tick) && ($past(tx_tick_r) == asp_pkg::ASP_TICK_LAST))
    else $error("transmit bit changed off the sixteenth tick");
  a_start_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(tx_st_r == TX_START) |-> !tx_line_r [*8])
    else $error("start bit not low");
  a_idle_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tx_st_r == TX_IDLE) && !lctl.brk && !loop_en |=> txd_r)
    else $error("idle transmit line not high");
  a_short_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_push && !len9 |-> ((rx_data & ~dmask) == 8'h00))
    else $error("unused receive bits not zero");
  a_dr_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    rxf_push |-> ##2 line_status_r[asp_pkg::ASP_LSR_DR])
    else $error("data ready missing after receive");
  a_lsr_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    lsr_rd && !rx_ovr && !(hd_chk_r && head_err) |=> !ls_pend_r)
    else $error("line status read did not clear");
  a_ring_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ms_delta_r[asp_pkg::ASP_MS_RI]) |->
    $past(md_prev_r[asp_pkg::ASP_MS_RI]) && !$past(md_in[asp_pkg::ASP_MS_RI]))
    else $error("ring delta without trailing edge");
  a_timeout_cond: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(to_pend_r) |-> $past(rxf_cnt_r < rx_trig) && $past(to_cnt_r >= to_lim))
    else $error("time-out raised without idle period");
endmodule

// File: tb/asp_far_end.sv
// Far-end serial device: frames characters onto rxd and samples txd
`timescale 1ns/1ps
module asp_far_end (
  input wire logic core_clk, // System clock
  input wire logic baud_tick, // Sixteen ticks per bit
  input wire logic txd, // Line from the port
  output logic rxd // Line into the port
);
  initial rxd = 1'b1;
  task automatic bit_time();
    repeat (16) @(posedge core_clk iff baud_tick);
  endtask
  task automatic send(input logic [8:0] d, input int n);
    rxd <= 1'b0;
    bit_time();
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      bit_time();
    end
    rxd <= 1'b1;
    bit_time();
  endtask
  task automatic recv(output logic [8:0] d, input int n);
    d = '0;
    @(negedge txd);
    // Sample mid-bit so edge jitter of a tick cannot flip a bit
    repeat (8) @(posedge core_clk iff baud_tick);
    for (int i = 0; i < n; i++) begin
      bit_time();
      d[i] = txd;
    end
  endtask
endmodule

// File: tb/test_asp_uart_top.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
module test_asp_uart_top;
  logic core_clk = 1'b0, rst_n = 1'b0, baud_tick = 1'b0, rts_on = 1'b0;
  logic thr_wr = 1'b0, rbr_rd = 1'b0, lsr_rd = 1'b0, msr_rd = 1'b0;
  logic cts_n = 1'b1, ri_n = 1'b1, thr_ready, txd, rxd, rts_n, dtr_n;
  logic rx_irq, holding_empty_flag_irq, temt_irq, ls_irq, ms_irq;
  logic [7:0] thr_data = 8'h00, rbr_data, line_status, modem_status;
  logic [8:0] got;
  logic fifo_en = 1'b1, loop_en = 1'b0;
  logic [4:0] rx_trig = 5'h01;
  asp_pkg::asp_lctl_type lctl = '0;
  asp_pkg::asp_ien_type int_en = 5'h1f;
  int err_count = 0, check_count = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) baud_tick <= ~baud_tick;
  asp_uart_top u_asp_uart_top (.core_clk(core_clk), .rst_n(rst_n),
    .baud_tick(baud_tick), .lctl(lctl), .fifo_en(fifo_en), .rx_trig(rx_trig),
    .loop_en(loop_en), .int_en(int_en), .mctl_rts(rts_on), .mctl_dtr(rts_on),
    .thr_wr(thr_wr), .thr_data(thr_data), .thr_ready(thr_ready),
    .rbr_rd(rbr_rd), .rbr_data(rbr_data), .lsr_rd(lsr_rd),
    .line_status(line_status), .msr_rd(msr_rd), .modem_status(modem_status),
    .rx_irq(rx_irq), .holding_empty_flag_irq(holding_empty_flag_irq), .temt_irq(temt_irq),
    .ls_irq(ls_irq), .ms_irq(ms_irq), .txd(txd), .rxd(rxd), .cts_n(cts_n),
    .dsr_n(cts_n), .dcd_n(cts_n), .ri_n(ri_n), .rts_n(rts_n), .dtr_n(dtr_n));
  asp_far_end u_asp_far_end (.core_clk(core_clk), .baud_tick(baud_tick),
    .txd(txd), .rxd(rxd));
  task automatic check(input logic [10:0] g, input logic [10:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_tx(input asp_pkg::asp_len_type ln,
      input asp_pkg::asp_par_type pr, input logic [7:0] d, input int n,
      input logic [8:0] e);
    @(posedge core_clk);
    lctl <= '{ln, pr, 1'b0, 1'b0};
    thr_data <= d;
    thr_wr <= 1'b1;
    @(posedge core_clk);
    thr_wr <= 1'b0;
    u_asp_far_end.recv(got, n);
    check(got, e);
    repeat (40) @(posedge core_clk iff baud_tick);
    @(negedge core_clk);
    check({txd, temt_irq}, 11'h003);
    $display("tx %h done", d);
  endtask
  task automatic t_rx(input asp_pkg::asp_len_type ln, input int n,
      input logic [8:0] d, input logic [7:0] e, input logic ls);
    @(posedge core_clk);
    lctl <= '{ln, asp_pkg::ASP_PAR_NONE, 1'b0, 1'b0};
    u_asp_far_end.send(d, n);
    repeat (4) @(negedge core_clk);
    check({line_status[0], rx_irq, ls_irq, rbr_data}, {2'b11, ls, e});
    @(posedge core_clk);
    rbr_rd <= 1'b1;
    lsr_rd <= 1'b1;
    @(posedge core_clk);
    rbr_rd <= 1'b0;
    lsr_rd <= 1'b0;
    repeat (3) @(negedge core_clk);
    check({line_status[0], ls_irq}, 11'h000);
    $display("rx %h done", d);
  endtask
  task automatic t_modem();
    @(posedge core_clk);
    ri_n <= 1'b0;
    rts_on <= 1'b1;
    repeat (8) @(negedge core_clk);
    check({rts_n, dtr_n, ms_irq, modem_status}, 11'h040);
    @(posedge core_clk);
    ri_n <= 1'b1;
    repeat (8) @(negedge core_clk);
    check({ms_irq, modem_status}, 11'h104);
    @(posedge core_clk);
    msr_rd <= 1'b1;
    @(posedge core_clk);
    msr_rd <= 1'b0;
    cts_n <= 1'b0;
    repeat (8) @(negedge core_clk);
    check({ms_irq, modem_status}, 11'h1bb);
    $display("modem done");
  endtask
  task automatic t_reset();
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge core_clk);
    check({thr_ready, txd, holding_empty_flag_irq, line_status}, 11'h760);
    $display("reset done");
  endtask
  task automatic t_ovr();
    @(posedge core_clk);
    lctl <= '{asp_pkg::ASP_LEN_8, asp_pkg::ASP_PAR_NONE, 1'b0, 1'b0};
    fifo_en <= 1'b0;
    u_asp_far_end.send(9'h011, 8);
    u_asp_far_end.send(9'h022, 8);
    repeat (2) @(negedge core_clk);
    check({line_status[1:0], ls_irq, rbr_data}, 11'h711);
    @(posedge core_clk);
    rbr_rd <= 1'b1;
    lsr_rd <= 1'b1;
    @(posedge core_clk);
    rbr_rd <= 1'b0;
    lsr_rd <= 1'b0;
    fifo_en <= 1'b1;
    repeat (3) @(negedge core_clk);
    check({line_status[1:0], ls_irq}, 11'h000);
    $display("overrun done");
  endtask
  task automatic t_timeout();
    @(posedge core_clk);
    rx_trig <= 5'h02;
    u_asp_far_end.send(9'h03c, 8);
    @(negedge core_clk);
    check({line_status[0], rx_irq}, 11'h002);
    // Four ten-bit characters of sixteen ticks each
    repeat (640) @(posedge core_clk iff baud_tick);
    @(negedge core_clk);
    check({line_status[0], rx_irq}, 11'h003);
    @(posedge core_clk);
    rbr_rd <= 1'b1;
    @(posedge core_clk);
    rbr_rd <= 1'b0;
    rx_trig <= 5'h01;
    repeat (3) @(negedge core_clk);
    check({line_status[0], rx_irq}, 11'h000);
    $display("time-out done");
  endtask
  task automatic t_loop();
    @(posedge core_clk);
    loop_en <= 1'b1;
    thr_data <= 8'h96;
    thr_wr <= 1'b1;
    @(posedge core_clk);
    thr_wr <= 1'b0;
    // Mid-frame, while a low data bit is being sent
    repeat (100) @(posedge core_clk iff baud_tick);
    @(negedge core_clk);
    check({txd, rts_n}, 11'h003);
    repeat (100) @(posedge core_clk iff baud_tick);
    @(negedge core_clk);
    check({line_status[0], rbr_data}, 11'h196);
    @(posedge core_clk);
    rbr_rd <= 1'b1;
    @(posedge core_clk);
    rbr_rd <= 1'b0;
    loop_en <= 1'b0;
    $display("loopback done");
  endtask
  initial begin
    // Bound is several times the expected run of a few thousand cycles
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    t_reset();
    t_tx(asp_pkg::ASP_LEN_8, asp_pkg::ASP_PAR_NONE, 8'ha5, 8, 9'h0a5);
    t_tx(asp_pkg::ASP_LEN_9, asp_pkg::ASP_PAR_MARK, 8'h33, 9, 9'h133);
    t_tx(asp_pkg::ASP_LEN_7, asp_pkg::ASP_PAR_EVEN, 8'h03, 8, 9'h003);
    t_tx(asp_pkg::ASP_LEN_7, asp_pkg::ASP_PAR_ODD, 8'h03, 8, 9'h083);
    t_rx(asp_pkg::ASP_LEN_8, 8, 9'h05a, 8'h5a, 1'b0);
    t_rx(asp_pkg::ASP_LEN_5, 5, 9'h01f, 8'h1f, 1'b0);
    t_rx(asp_pkg::ASP_LEN_9, 9, 9'h1c3, 8'hc3, 1'b1);
    t_ovr();
    t_timeout();
    t_loop();
    t_modem();
    test_done();
  end
endmodule
